//--- hw/rbp_reset_boot.sv
// reset pins, processor vector start, boot pin capture and clock output
`timescale 1ns/10ps
`default_nettype none

module rbp_reset_boot
    import rbp_pkg::*;
#(
    parameter int unsigned WDOG_LEN = RBP_WDOG_RST_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic power_on_fault,
    input wire logic brown_out_reset,
    input wire logic wdog_reset_req,
    input wire logic digital_reset_pin_in,
    output logic digital_reset_pin_out,
    output logic digital_reset_pin_oe,
    input wire logic analog_power_on_fault,
    input wire logic analog_brown_out_reset,
    input wire logic analog_reset_pin_in,
    output logic analog_reset_pin_out,
    output logic analog_reset_pin_oe,
    output logic analog_logic_reset,
    output logic digital_reset,
    output logic digital_halt,
    output logic [RBP_APP_AW-1:0] app_vector_addr,
    input wire logic [RBP_APP_AW-1:0] app_vector_data,
    output logic [RBP_CTRL_AW-1:0] ctrl_vector_addr,
    input wire logic [RBP_CTRL_AW-1:0] ctrl_vector_data,
    output logic app_fetch_en,
    output logic [RBP_APP_AW-1:0] app_fetch_addr,
    output logic ctrl_fetch_en,
    output logic [RBP_CTRL_AW-1:0] ctrl_fetch_addr,
    input wire logic pll_sysclk,
    input wire logic [1:0] clock_out_divider_config,
    output logic divided_clock_output,
    input wire logic [RBP_BOOT_W-1:0] boot_pins,
    output logic [RBP_BOOT_W-1:0] boot_mode,
    output logic boot_mode_valid,
    input wire logic external_oscillator_input,
    output logic usb_pll_ref_clk,
    output logic can_clk
);

    rbp_state_e state;
    rbp_state_e next_state;
    logic por_bor_q;
    logic wdog_busy;
    logic dig_rst_q;
    logic ana_drive_q;
    logic ana_rst_q;
    logic pll_prev;
    logic div4_phase;
    logic pll_rise;
    logic [RBP_APP_AW-1:0] app_pc;
    logic [RBP_CTRL_AW-1:0] ctrl_pc;

    rbp_stretch_if #(.LEN(WDOG_LEN)) wdog_if ();

    // watchdog pulse of fixed length in oscillator cycles
    rbp_pulse_stretch #(
        .LEN(WDOG_LEN)
    ) u_wdog_stretch (
        .mclk(mclk),
        .resetn(resetn),
        .st(wdog_if.stretcher)
    );

    // a watchdog request is only honoured when the pulse is idle
    assign wdog_if.trigger = wdog_reset_req;
    assign wdog_busy = wdog_if.busy;

    // power faults held in a flop so the pin drive is glitch free
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            por_bor_q <= 1'b1;
        end else begin
            por_bor_q <= power_on_fault | brown_out_reset;
        end
    end

    // open-drain digital reset pin: low level only, enable while driving
    assign digital_reset_pin_out = 1'b0;
    assign digital_reset_pin_oe = por_bor_q | wdog_busy;

    // internal reset collects every source; the pin level covers an
    // outside driver, which wins over our released pull-up
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            dig_rst_q <= 1'b1;
        end else begin
            dig_rst_q <= por_bor_q | wdog_busy | !digital_reset_pin_in;
        end
    end

    assign digital_reset = dig_rst_q;
    // halt follows the state, so execution stops for any reset source
    assign digital_halt = (state != RBP_RUN);

    // sequencing: hold while reset, one boot cycle, then run
    always_comb begin
        next_state = state;
        case (state)
            RBP_HOLD: begin
                if (!dig_rst_q) begin
                    next_state = RBP_BOOT;
                end
            end
            RBP_BOOT: begin
                if (dig_rst_q) begin
                    next_state = RBP_HOLD;
                end else begin
                    next_state = RBP_RUN;
                end
            end
            RBP_RUN: begin
                if (dig_rst_q) begin
                    next_state = RBP_HOLD;
                end
            end
            default: begin
                next_state = RBP_HOLD;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state <= RBP_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // vector addresses stay on the vector bus from reset onward
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            app_vector_addr <= RBP_APP_VECTOR_LOC;
            ctrl_vector_addr <= RBP_CTRL_VECTOR_LOC;
        end else begin
            app_vector_addr <= RBP_APP_VECTOR_LOC;
            ctrl_vector_addr <= RBP_CTRL_VECTOR_LOC;
        end
    end

    // program counters reload from the vector words all through reset;
    // the last word seen before release is the start address
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            app_pc <= '0;
            ctrl_pc <= '0;
        end else if (state == RBP_HOLD) begin
            app_pc <= app_vector_data;
            ctrl_pc <= ctrl_vector_data;
        end
    end

    // fetching starts at the loaded counters once running
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            app_fetch_en <= 1'b0;
            ctrl_fetch_en <= 1'b0;
            app_fetch_addr <= '0;
            ctrl_fetch_addr <= '0;
        end else begin
            app_fetch_en <= (next_state == RBP_RUN);
            ctrl_fetch_en <= (next_state == RBP_RUN);
            app_fetch_addr <= app_pc;
            ctrl_fetch_addr <= ctrl_pc;
        end
    end

    // boot pins are taken as one group in the cycle after release,
    // so all three bits come from the same edge
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            boot_mode <= RBP_BOOT_RESET;
            boot_mode_valid <= 1'b0;
        end else if (state == RBP_BOOT) begin
            boot_mode <= boot_pins;
            boot_mode_valid <= !dig_rst_q;
        end else if (state == RBP_HOLD) begin
            boot_mode_valid <= 1'b0;
        end
    end

    // analog reset pin drive during analog power faults
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ana_drive_q <= 1'b1;
        end else begin
            ana_drive_q <= analog_power_on_fault | analog_brown_out_reset;
        end
    end

    assign analog_reset_pin_out = 1'b0;
    assign analog_reset_pin_oe = ana_drive_q;

    // analog logic reset from our own drive or any outside pull-down
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ana_rst_q <= 1'b1;
        end else begin
            ana_rst_q <= ana_drive_q | !analog_reset_pin_in;
        end
    end

    assign analog_logic_reset = ana_rst_q;

    // clock output: the PLL clock is sampled, so the output is only
    // faithful while the PLL clock is well below the sampling rate
    assign pll_rise = pll_sysclk & !pll_prev;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pll_prev <= 1'b0;
            div4_phase <= 1'b0;
        end else begin
            pll_prev <= pll_sysclk;
            if (pll_rise) begin
                div4_phase <= !div4_phase;
            end
        end
    end

    // divide by one copies, by two toggles each rise, by four every second
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            divided_clock_output <= 1'b0;
        end else begin
            case (clock_out_divider_config)
                RBP_DIV_BY1: begin
                    divided_clock_output <= pll_sysclk;
                end
                RBP_DIV_BY2: begin
                    if (pll_rise) begin
                        divided_clock_output <= !divided_clock_output;
                    end
                end
                RBP_DIV_BY4: begin
                    if (pll_rise && div4_phase) begin
                        divided_clock_output <= !divided_clock_output;
                    end
                end
                default: begin
                    divided_clock_output <= pll_sysclk;
                end
            endcase
        end
    end

    // oscillator input is a clock route, not data, so it is not retimed
    assign usb_pll_ref_clk = external_oscillator_input;
    assign can_clk = external_oscillator_input;

endmodule
`default_nettype wire

//--- pkg/rbp_pkg.sv
// constants and types shared by the reset, boot and clock-out block
package rbp_pkg;

    // watchdog reset pulse length, in oscillator clock cycles
    localparam int unsigned RBP_WDOG_RST_CYCLES = 512;

    // reset vector locations read by each processor during reset
    localparam logic [31:0] RBP_APP_VECTOR_LOC = 32'h0000_0004;
    localparam logic [21:0] RBP_CTRL_VECTOR_LOC = 22'h3F_FFC0;

    // widths of the two processor address spaces
    localparam int unsigned RBP_APP_AW = 32;
    localparam int unsigned RBP_CTRL_AW = 22;

    // boot-select pin group
    localparam int unsigned RBP_BOOT_W = 3;
    localparam logic [2:0] RBP_BOOT_RESET = 3'h0;

    // clock-out divider configuration codes
    localparam logic [1:0] RBP_DIV_BY4 = 2'h0;
    localparam logic [1:0] RBP_DIV_BY2 = 2'h1;
    localparam logic [1:0] RBP_DIV_BY1 = 2'h2;

    // sequencing states, one-hot
    typedef enum logic [2:0] {
        RBP_HOLD = 3'h1,
        RBP_BOOT = 3'h2,
        RBP_RUN  = 3'h4
    } rbp_state_e;

endpackage

//--- pkg/rbp_stretch_if.sv
// carrier between the sequencer and its reset pulse stretcher
`timescale 1ns/10ps
`default_nettype none
interface rbp_stretch_if #(
    parameter int unsigned LEN = rbp_pkg::RBP_WDOG_RST_CYCLES
);
    logic trigger;
    logic busy;
    logic [$clog2(LEN+1)-1:0] remaining;

    // sequencer side requests a pulse and watches it
    modport owner (
        output trigger,
        input busy,
        input remaining
    );

    // stretcher side produces the pulse
    modport stretcher (
        input trigger,
        output busy,
        output remaining
    );
endinterface
`default_nettype wire

//--- hw/rbp_pulse_stretch.sv
// fixed-length reset pulse stretcher
`timescale 1ns/10ps
`default_nettype none
module rbp_pulse_stretch
    import rbp_pkg::*;
#(
    parameter int unsigned LEN = RBP_WDOG_RST_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    rbp_stretch_if.stretcher st
);
    localparam int unsigned CW = $clog2(LEN+1);
    localparam logic [CW-1:0] LAST = CW'(LEN - 1);

    // busy stands exactly LEN cycles from the cycle after the trigger;
    // a trigger while busy is ignored so a repeat cannot lengthen it
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st.busy <= 1'b0;
            st.remaining <= '0;
        end else if (st.trigger && !st.busy) begin
            st.busy <= 1'b1;
            st.remaining <= LAST;
        end else if (st.busy) begin
            if (st.remaining == '0) begin
                st.busy <= 1'b0;
            end else begin
                st.remaining <= st.remaining - CW'(1);
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/rbp_reset_boot_chk.sv
// port assertions for the reset, boot and clock-out block
`timescale 1ns/10ps
`default_nettype none
module rbp_reset_boot_chk
    import rbp_pkg::*;
#(
    parameter int unsigned WDOG_LEN = RBP_WDOG_RST_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic power_on_fault,
    input wire logic brown_out_reset,
    input wire logic wdog_reset_req,
    input wire logic digital_reset_pin_in,
    input wire logic digital_reset_pin_oe,
    input wire logic analog_power_on_fault,
    input wire logic analog_brown_out_reset,
    input wire logic analog_reset_pin_in,
    input wire logic analog_reset_pin_oe,
    input wire logic analog_logic_reset,
    input wire logic digital_reset,
    input wire logic digital_halt,
    input wire logic [RBP_APP_AW-1:0] app_vector_data,
    input wire logic [RBP_CTRL_AW-1:0] ctrl_vector_data,
    input wire logic app_fetch_en,
    input wire logic [RBP_APP_AW-1:0] app_fetch_addr,
    input wire logic ctrl_fetch_en,
    input wire logic [RBP_CTRL_AW-1:0] ctrl_fetch_addr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // pulse length written for the shortened bench value of 8
    sequence wd_take;
        wdog_reset_req && !digital_reset_pin_oe;
    endsequence
    sequence wd_pulse;
        digital_reset_pin_oe [*8] ##1 !digital_reset_pin_oe;
    endsequence
    // boot step then run, once the internal reset lets go
    sequence boot_steps;
        !app_fetch_en ##1 (app_fetch_en && ctrl_fetch_en && !digital_halt);
    endsequence

    a_fault_drives_pin: assert property (
        (power_on_fault || brown_out_reset) |=> digital_reset_pin_oe)
        else $error("digital pin not driven on power fault");
    // a power fault may legally stretch the pulse, so it drops the attempt
    a_wdog_pulse_len: assert property (
        disable iff (!resetn || power_on_fault || brown_out_reset) wd_take |=> wd_pulse)
        else $error("watchdog pulse length wrong");
    a_reset_follows: assert property (
        digital_reset == $past(digital_reset_pin_oe || !digital_reset_pin_in))
        else $error("internal reset not the or of its sources");
    a_reset_halts: assert property (
        digital_reset |=> (digital_halt && !app_fetch_en && !ctrl_fetch_en))
        else $error("execution not halted in reset");
    a_boot_order: assert property (
        $fell(digital_reset) |=> boot_steps)
        else $error("fetch start out of order");
    a_start_vectors: assert property (
        $rose(app_fetch_en) |-> (app_fetch_addr == $past(app_vector_data, 2)
        && ctrl_fetch_addr == $past(ctrl_vector_data, 2)))
        else $error("start address not the loaded vector");
    a_analog_pin: assert property (
        (analog_power_on_fault || analog_brown_out_reset) |=> analog_reset_pin_oe)
        else $error("analog pin not driven on fault");
    a_analog_logic: assert property (
        (analog_reset_pin_oe || !analog_reset_pin_in) |=> analog_logic_reset)
        else $error("analog logic not held in reset");
endmodule

bind rbp_reset_boot rbp_reset_boot_chk #(.WDOG_LEN(WDOG_LEN)) i_rbp_reset_boot_chk (
    .mclk(mclk), .resetn(resetn), .power_on_fault(power_on_fault),
    .brown_out_reset(brown_out_reset), .wdog_reset_req(wdog_reset_req),
    .digital_reset_pin_in(digital_reset_pin_in), .digital_reset_pin_oe(digital_reset_pin_oe),
    .analog_power_on_fault(analog_power_on_fault),
    .analog_brown_out_reset(analog_brown_out_reset),
    .analog_reset_pin_in(analog_reset_pin_in), .analog_reset_pin_oe(analog_reset_pin_oe),
    .analog_logic_reset(analog_logic_reset), .digital_reset(digital_reset),
    .digital_halt(digital_halt), .app_vector_data(app_vector_data),
    .ctrl_vector_data(ctrl_vector_data), .app_fetch_en(app_fetch_en),
    .app_fetch_addr(app_fetch_addr), .ctrl_fetch_en(ctrl_fetch_en),
    .ctrl_fetch_addr(ctrl_fetch_addr));
`default_nettype wire

//--- bench/rbp_board.sv
// board side of the two reset pins: pull-ups and outside open-drain drivers
`timescale 1ns/10ps
`default_nettype none
module rbp_board (
    input wire logic dig_oe,
    input wire logic dig_out,
    input wire logic ana_oe,
    input wire logic ana_out,
    input wire logic ext_dig,
    input wire logic ext_ana,
    output logic dig_pin,
    output logic ana_pin
);
    // pull-up wins unless some party sinks the wire, never a fight
    assign dig_pin = (dig_oe ? dig_out : 1'h1) & !ext_dig;
    assign ana_pin = (ana_oe ? ana_out : 1'h1) & !ext_ana;
endmodule
`default_nettype wire

//--- bench/tb_rbp_reset_boot.sv
// self-checking bench for the reset, boot and clock-out block
`timescale 1ns/10ps
`default_nettype none
module tb_rbp_reset_boot;
    import rbp_pkg::*;
    localparam int unsigned WL = 8;
    logic mclk, resetn, por, bor, wdr, dpi, dpo, doe, apor, abor, api, apo, aoe, alr;
    logic drst, halt, aen, cen, pll, dco, bval, osc, usb, can, ext_d, ext_a, prev;
    logic [31:0] avd, aaddr, afa;
    logic [21:0] cvd, caddr, cfa;
    logic [1:0] cfg;
    logic [2:0] bpins, bmode;
    int err_total, cmp_count, n, i, k;
    // divider code beside the rises expected in 32 cycles, pll period 2
    logic [1:0] row_cfg [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    int row_rise [4] = '{4, 8, 16, 16};

    rbp_reset_boot #(.WDOG_LEN(WL)) i_rbp_reset_boot (
        .mclk(mclk), .resetn(resetn), .power_on_fault(por), .brown_out_reset(bor),
        .wdog_reset_req(wdr), .digital_reset_pin_in(dpi), .digital_reset_pin_out(dpo),
        .digital_reset_pin_oe(doe), .analog_power_on_fault(apor),
        .analog_brown_out_reset(abor), .analog_reset_pin_in(api),
        .analog_reset_pin_out(apo), .analog_reset_pin_oe(aoe), .analog_logic_reset(alr),
        .digital_reset(drst), .digital_halt(halt), .app_vector_addr(aaddr),
        .app_vector_data(avd), .ctrl_vector_addr(caddr), .ctrl_vector_data(cvd),
        .app_fetch_en(aen), .app_fetch_addr(afa), .ctrl_fetch_en(cen),
        .ctrl_fetch_addr(cfa), .pll_sysclk(pll), .clock_out_divider_config(cfg),
        .divided_clock_output(dco), .boot_pins(bpins), .boot_mode(bmode),
        .boot_mode_valid(bval), .external_oscillator_input(osc),
        .usb_pll_ref_clk(usb), .can_clk(can));
    rbp_board i_rbp_board (.dig_oe(doe), .dig_out(dpo), .ana_oe(aoe), .ana_out(apo),
        .ext_dig(ext_d), .ext_ana(ext_a), .dig_pin(dpi), .ana_pin(api));

    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end
    // pll seen as data, toggling every cycle
    always @(posedge mclk) pll <= #1 ~pll;

    task tick(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // bounded wait for the processors to run again
    task wait_run(input string name);
        for (k = 0; k < 40 && aen !== 1'h1; k++) tick(1);
        if (aen !== 1'h1) begin
            err_total++;
            stop_test;
        end else $display("test %s done", name);
    endtask

    initial begin
        {resetn, por, bor, wdr, apor, abor, ext_d, ext_a, osc, pll} = '0;
        cfg = 2'h2;
        bpins = 3'h5;
        avd = 32'h0000_8001;
        cvd = 22'h01_2345;
        err_total = 0;
        cmp_count = 0;
        tick(4);
        chk({doe, dpo, apo, drst, alr}, 5'h13);
        chk({halt, aen, cen, bval}, 4'h8);
        chk(aaddr, 32'h0000_0004);
        chk(caddr, 22'h3F_FFC0);
        resetn = 1'h1;
        wait_run("reset");
        chk(afa, avd);
        chk(cfa, cvd);
        chk({halt, bval, bmode}, 5'h0D);
        bpins = 3'h2;
        tick(3);
        chk(bmode, 3'h5);
        for (i = 0; i < 4; i++) begin
            cfg = row_cfg[i];
            tick(8);
            n = 0;
            prev = dco;
            for (k = 0; k < 32; k++) begin
                tick(1);
                if (dco === 1'h1 && prev === 1'h0) n++;
                prev = dco;
            end
            chk(n, row_rise[i]);
        end
        for (i = 0; i < 2; i++) begin
            osc = i[0];
            tick(1);
            chk({usb, can}, {2{osc}});
        end
        $display("test clocks done");
        // each power fault in turn, new vectors loaded while held
        for (i = 0; i < 2; i++) begin
            {bor, por} = 2'(i + 1);
            avd = avd + 32'h10;
            cvd = cvd + 22'h4;
            tick(3);
            chk({doe, dpi, halt, aen}, 4'hA);
            {bor, por} = 2'h0;
            wait_run("power fault");
            chk(afa, avd);
            chk(cfa, cvd);
        end
        // request held three cycles: repeats during the pulse are refused
        wdr = 1'h1;
        tick(3);
        wdr = 1'h0;
        n = 3;
        for (k = 0; k < 20; k++) begin
            tick(1);
            if (doe === 1'h1) n++;
        end
        chk(n, WL);
        wait_run("watchdog");
        ext_d = 1'h1;
        tick(3);
        chk({drst, halt, doe}, 3'h6);
        ext_d = 1'h0;
        wait_run("outside pull");
        // analog faults, then an outside pull on the analog pin
        for (i = 0; i < 3; i++) begin
            {ext_a, abor, apor} = 3'(1 << i);
            tick(3);
            chk({alr, aoe, api}, {1'h1, i < 2, 1'h0});
            {ext_a, abor, apor} = 3'h0;
            tick(3);
            chk(alr, 1'h0);
        end
        $display("test analog done");
        resetn = 1'h0;
        tick(2);
        chk(drst, 1'h1);
        resetn = 1'h1;
        wait_run("second reset");
        stop_test;
    end
endmodule
`default_nettype wire
